// >>> dma_chan_defines.svh
/*
  Register offsets, field positions, reset values and sizes for one DMA
  channel control block. Assumes byte addresses on the register bus.
*/
`ifndef DMA_CHAN_DEFINES_SVH
`define DMA_CHAN_DEFINES_SVH

`define OFS_ACTIVATE 8'h00
`define OFS_MEM_START 8'h04
`define OFS_MEM_END 8'h08
`define OFS_DEV_ADDR 8'h0C
`define OFS_CONTROL 8'h10
`define OFS_STATUS 8'h14
`define OFS_MAIN_ACT 8'h30

`define CTL_ABORT 25
`define CTL_GO 24
`define CTL_SIZE_HI 22
`define CTL_SIZE_LO 20
`define CTL_HWDIS 19
`define CTL_LOCK 18
`define CTL_INCDEV 17
`define CTL_INCMEM 16
`define CTL_SRC_HI 15
`define CTL_SRC_LO 9
`define CTL_DIR 8
`define CTL_BUSY 5
`define CTL_DONE 2
`define CTL_REQ 1
`define CTL_RUN 0

`define STS_DONE 2
`define STS_BUSERR 0

`define REG_RESET 32'h0000_0000
`define FIFO_WIDTH 32
`define FIFO_DEPTH 8
`define FC_WIDTH 128

`endif

// >>> dma_chan_far_model.sv
/*
  Far-side model: arbiter, internal bus slave and pacing masters.
  Assumes the channel control block's registered ibus request.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dma_chan_defines.svh"
module dma_chan_far_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic arb_req,
  output logic arb_grant,
  input wire dma_chan_pkg::ibus_req_t ibus_o,
  output logic ibus_ack,
  output logic ibus_err,
  output logic [31:0] ibus_rdata,
  output logic [`FC_WIDTH-1:0] fc_req,
  output logic [`FC_WIDTH-1:0] fc_term,
  input wire logic [6:0] idx,
  input wire logic req_on,
  input wire logic term_on,
  input wire logic err_on,
  input wire logic [3:0] dly,
  output int rd_cnt,
  output int wr_cnt,
  output logic [31:0] last_raddr,
  output logic [31:0] last_waddr,
  output logic [31:0] last_wdata
);
  logic [3:0] wcnt;
  logic [31:0] pat;
  logic [`FC_WIDTH-1:0] one_hot;
  // read data is only meaningful with ack; inverted otherwise
  assign pat = {ibus_o.addr[15:0], 16'h5AC3};
  assign ibus_rdata = ibus_ack ? pat : ~pat;
  // pacing request level on one bus index
  assign one_hot = {{(`FC_WIDTH-1){1'b0}}, 1'b1} << idx;
  assign fc_req = req_on ? one_hot : '0;
  assign fc_term = term_on ? one_hot : '0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arb_grant <= 1'b0;
      ibus_ack <= 1'b0;
      ibus_err <= 1'b0;
      wcnt <= 4'h0;
      rd_cnt <= 0;
      wr_cnt <= 0;
      last_raddr <= 32'h0;
      last_waddr <= 32'h0;
      last_wdata <= 32'h0;
    end else begin
      arb_grant <= arb_req;
      ibus_ack <= 1'b0;
      ibus_err <= 1'b0;
      if (!ibus_o.req) begin
        wcnt <= 4'h0;
      end else if (!ibus_ack) begin
        if (wcnt < dly) begin
          wcnt <= wcnt + 4'h1;
        end else begin
          wcnt <= 4'h0;
          ibus_ack <= 1'b1;
          ibus_err <= err_on;
          if (ibus_o.we) begin
            wr_cnt <= wr_cnt + 1;
            last_waddr <= ibus_o.addr;
            last_wdata <= ibus_o.wdata;
          end else begin
            rd_cnt <= rd_cnt + 1;
            last_raddr <= ibus_o.addr;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> dma_chan_fifo.sv
/*
  Small flip-flop FIFO with valid/ready on both sides and a flush.
  Assumes a single clock and DEPTH a power of two.
*/
`timescale 1ns/10ps
`default_nettype none
module dma_chan_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule
`default_nettype wire

// >>> dma_chan_pkg.sv
/*
  Types shared by the channel control block.
  Assumes dma_chan_defines.svh supplies the numeric constants.
*/
package dma_chan_pkg;

  typedef struct packed {
    logic abort;
    logic go;
    logic [2:0] size;
    logic hw_dis;
    logic lock;
    logic inc_dev;
    logic inc_mem;
    logic [6:0] src;
    logic dir;
    logic run;
  } ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARB = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b011,
    ST_STEP = 3'b100
  } chan_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [2:0] size;
  } ibus_req_t;

endpackage

// >>> dma_channel_control.sv
/*
  One DMA channel: register slave on Avalon-MM, channel sequencer, packet
  mover over a simple internal bus, with a FIFO between read and write.
  Assumes synchronous inputs, an external arbiter and pacing masters.
*/
// Design decision made here: the Avalon-MM slave port.
// What this block does
// R1: setting abort ends the running transfer at once, no more packets.
// R2: go starts a firmware-paced transfer; only with hardware pacing disabled.
// R3: size field gives bytes per packet; software uses only 1, 2 or 4.
// R4: with pacing disabled, requests on the flow-control bus are ignored.
// R5: software should disable hardware pacing before firmware-paced use.
// R6: with lock set, arbiter keeps this channel granted until transfer ends.
// R7: device address steps by packet size after each packet when enabled.
// R8: memory address steps by packet size after each packet when enabled.
// R9: without memory stepping the channel never ends a transfer itself; in hardware-paced mode this block returns to idle after every packet.
// R10: source field picks which flow-control bus index paces this channel.
// R11: direction one reads memory then writes device; zero the reverse.
// R12: busy reads one whenever the sequencer is not idle.
// R13: done reads not-busy and run; zero when run is off.
// R14: request reads one while the selected master is requesting.
// R15: in hardware-paced mode run enables servicing; zero ignores requests.
// R16: memory start reaching memory end completes and raises the done flag.
// R17: channel works only with both its own and the main activate set.
// R18: fields and status clear at reset; reserved bits read zero.
// R19: go and abort clear when the channel returns to idle.
`timescale 1ns/10ps
`default_nettype none
`include "dma_chan_defines.svh"
module dma_channel_control (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [`FC_WIDTH-1:0] fc_req,
  input wire logic [`FC_WIDTH-1:0] fc_term,
  output logic fc_done,
  output logic arb_req,
  output logic arb_lock,
  input wire logic arb_grant,
  output dma_chan_pkg::ibus_req_t ibus_o,
  input wire logic ibus_ack,
  input wire logic ibus_err,
  input wire logic [31:0] ibus_rdata
);
  dma_chan_pkg::chan_state_t state;
  dma_chan_pkg::chan_state_t next_state;
  dma_chan_pkg::ctrl_t ctrl;
  dma_chan_pkg::ctrl_t next_ctrl;
  logic ch_act;
  logic main_act;
  logic [31:0] mem_addr;
  logic [31:0] mem_end;
  logic [31:0] dev_addr;
  logic st_done;
  logic st_err;

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // register bus decode
  wire wr_fire = avs_write && !avs_waitrequest;
  wire hit_act = (avs_address == `OFS_ACTIVATE);
  wire hit_mst = (avs_address == `OFS_MEM_START);
  wire hit_mend = (avs_address == `OFS_MEM_END);
  wire hit_dev = (avs_address == `OFS_DEV_ADDR);
  wire hit_ctl = (avs_address == `OFS_CONTROL);
  wire hit_sts = (avs_address == `OFS_STATUS);
  wire hit_main = (avs_address == `OFS_MAIN_ACT);
  wire wr_ctl = wr_fire && hit_ctl;

  // channel status
  wire busy = (state != dma_chan_pkg::ST_IDLE); // R12
  wire done_sts = !busy && ctrl.run; // R13
  wire sel_req = fc_req[ctrl.src]; // R10 R14
  wire sel_term = fc_term[ctrl.src]; // R10
  wire operational = ch_act && main_act; // R17
  wire hw_go = !ctrl.hw_dis && ctrl.run && sel_req; // R4 R15
  wire fw_go = ctrl.hw_dis && ctrl.go; // R2
  wire start = operational && (ctrl.hw_dis ? fw_go : hw_go);
  wire hw_term = !ctrl.hw_dis && sel_term;
  wire kill = ctrl.abort || hw_term || !operational; // R1
  wire [31:0] step = {29'h0, ctrl.size}; // R3
  wire [31:0] next_mem = mem_addr + step;
  wire [31:0] next_dev = dev_addr + step;
  wire end_hit = ctrl.inc_mem && (next_mem == mem_end); // R9 R16
  wire [31:0] rd_addr = ctrl.dir ? mem_addr : dev_addr; // R11
  wire [31:0] wr_addr = ctrl.dir ? dev_addr : mem_addr; // R11
  wire bus_phase = (state == dma_chan_pkg::ST_READ) || (state == dma_chan_pkg::ST_WRITE);
  wire bus_fail = bus_phase && ibus_ack && ibus_err;
  wire to_idle = busy && (next_state == dma_chan_pkg::ST_IDLE);
  wire go_clr = to_idle || (!busy && ctrl.abort);

  // fifo hookup
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_out_data;
  wire fifo_push = (state == dma_chan_pkg::ST_READ) && ibus_ack && !ibus_err;
  wire fifo_pop = (state == dma_chan_pkg::ST_WRITE) && !ibus_o.req && fifo_out_valid;
  wire fifo_flush = to_idle;
  wire launch_rd = (state == dma_chan_pkg::ST_ARB) && (next_state == dma_chan_pkg::ST_READ);

  wire [31:0] ctl_word = {6'h0, ctrl.abort, ctrl.go, 1'b0, ctrl.size, ctrl.hw_dis,
                          ctrl.lock, ctrl.inc_dev, ctrl.inc_mem, ctrl.src, ctrl.dir,
                          2'b00, busy, 2'b00, done_sts, sel_req, ctrl.run}; // R18
  wire [31:0] sts_word = {29'h0, st_done, 1'b0, st_err};
  wire [31:0] ctl_new = be_merge(ctl_word, avs_writedata, avs_byteenable);
  wire [31:0] rd_word = hit_act ? {31'h0, ch_act} :
                        hit_mst ? mem_addr :
                        hit_mend ? mem_end :
                        hit_dev ? dev_addr :
                        hit_ctl ? ctl_word :
                        hit_sts ? sts_word :
                        hit_main ? {31'h0, main_act} : 32'h0000_0000;
  wire sts_clr_done = wr_fire && hit_sts && avs_byteenable[0] && avs_writedata[`STS_DONE];
  wire sts_clr_err = wr_fire && hit_sts && avs_byteenable[0] && avs_writedata[`STS_BUSERR];
  wire set_done = (state == dma_chan_pkg::ST_STEP) && end_hit; // R16

  dma_chan_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flush(fifo_flush),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(ibus_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // bus slave: one wait cycle per access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= `REG_RESET;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) avs_readdata <= rd_word;
    end
  end

  // control field update, software write beats hardware clear
  always_comb begin
    next_ctrl = ctrl;
    if (go_clr) begin
      next_ctrl.go = 1'b0; // R19
      next_ctrl.abort = 1'b0; // R19
    end
    if (wr_ctl) begin
      next_ctrl.abort = ctl_new[`CTL_ABORT];
      next_ctrl.go = ctl_new[`CTL_GO];
      next_ctrl.size = ctl_new[`CTL_SIZE_HI:`CTL_SIZE_LO];
      next_ctrl.hw_dis = ctl_new[`CTL_HWDIS];
      next_ctrl.lock = ctl_new[`CTL_LOCK];
      next_ctrl.inc_dev = ctl_new[`CTL_INCDEV];
      next_ctrl.inc_mem = ctl_new[`CTL_INCMEM];
      next_ctrl.src = ctl_new[`CTL_SRC_HI:`CTL_SRC_LO];
      next_ctrl.dir = ctl_new[`CTL_DIR];
      next_ctrl.run = ctl_new[`CTL_RUN];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0; // R18
      ch_act <= 1'b0;
      main_act <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      if (wr_fire && hit_act && avs_byteenable[0]) ch_act <= avs_writedata[0];
      if (wr_fire && hit_main && avs_byteenable[0]) main_act <= avs_writedata[0];
    end
  end

  // address registers, hardware step wins over software write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr <= `REG_RESET;
      mem_end <= `REG_RESET;
      dev_addr <= `REG_RESET;
    end else begin
      if (state == dma_chan_pkg::ST_STEP && ctrl.inc_mem) mem_addr <= next_mem; // R8
      else if (wr_fire && hit_mst) mem_addr <= be_merge(mem_addr, avs_writedata, avs_byteenable);
      if (state == dma_chan_pkg::ST_STEP && ctrl.inc_dev) dev_addr <= next_dev; // R7
      else if (wr_fire && hit_dev) dev_addr <= be_merge(dev_addr, avs_writedata, avs_byteenable);
      if (wr_fire && hit_mend) mem_end <= be_merge(mem_end, avs_writedata, avs_byteenable);
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_done <= 1'b0;
      st_err <= 1'b0;
    end else begin
      st_done <= set_done || (st_done && !sts_clr_done); // R16
      st_err <= bus_fail || (st_err && !sts_clr_err);
    end
  end

  // channel sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      dma_chan_pkg::ST_IDLE: begin
        if (start) next_state = dma_chan_pkg::ST_ARB; // R2 R15
      end
      dma_chan_pkg::ST_ARB: begin
        if (kill) next_state = dma_chan_pkg::ST_IDLE; // R1
        else if (arb_grant && fifo_in_ready) next_state = dma_chan_pkg::ST_READ;
      end
      dma_chan_pkg::ST_READ: begin
        if (kill || bus_fail) next_state = dma_chan_pkg::ST_IDLE; // R1
        else if (ibus_ack) next_state = dma_chan_pkg::ST_WRITE;
      end
      dma_chan_pkg::ST_WRITE: begin
        if (kill || bus_fail) next_state = dma_chan_pkg::ST_IDLE; // R1
        else if (ibus_ack) next_state = dma_chan_pkg::ST_STEP;
      end
      dma_chan_pkg::ST_STEP: begin
        if (kill || end_hit || !ctrl.hw_dis) next_state = dma_chan_pkg::ST_IDLE; // R9
        else next_state = dma_chan_pkg::ST_ARB;
      end
      default: next_state = dma_chan_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= dma_chan_pkg::ST_IDLE;
      arb_req <= 1'b0;
      arb_lock <= 1'b0;
      fc_done <= 1'b0;
    end else begin
      state <= next_state;
      arb_req <= (next_state != dma_chan_pkg::ST_IDLE);
      arb_lock <= ctrl.lock && (next_state != dma_chan_pkg::ST_IDLE); // R6
      fc_done <= (state == dma_chan_pkg::ST_STEP) && !ctrl.hw_dis;
    end
  end

  // internal bus request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ibus_o <= '0;
    end else if (launch_rd) begin
      ibus_o <= '{1'b1, 1'b0, rd_addr, 32'h0000_0000, ctrl.size}; // R11
    end else if (fifo_pop) begin
      ibus_o <= '{1'b1, 1'b1, wr_addr, fifo_out_data, ctrl.size}; // R11
    end else if (ibus_ack || to_idle) begin
      ibus_o.req <= 1'b0; // R1
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_abort_stops: assert property (busy && ctrl.abort |=> !busy) // R1
    else $error("abort did not end transfer");
  chk_fw_start: assert property (!busy && fw_go && operational // R2
                                 |=> state == dma_chan_pkg::ST_ARB)
    else $error("go did not start transfer");
  chk_hw_start: assert property (!busy && operational && !ctrl.hw_dis && ctrl.run // R15
                                 && sel_req |=> busy)
    else $error("paced request not served");
  chk_size_out: assert property ($rose(ibus_o.req) |-> ibus_o.size == ctrl.size) // R3
    else $error("packet size not carried");
  chk_hwdis_ignore: assert property (!busy && ctrl.hw_dis && !ctrl.go |=> !busy) // R4
    else $error("request taken while pacing disabled");
  chk_lock_hold: assert property (arb_lock |-> arb_req && busy) // R6
    else $error("lock without request");
  chk_dev_step: assert property (state == dma_chan_pkg::ST_STEP && ctrl.inc_dev // R7
                                 |=> dev_addr == $past(dev_addr) + $past(step))
    else $error("device address not stepped");
  chk_mem_step: assert property (state == dma_chan_pkg::ST_STEP && ctrl.inc_mem // R8
                                 |=> mem_addr == $past(mem_addr) + $past(step))
    else $error("memory address not stepped");
  chk_noinc_runs: assert property (state == dma_chan_pkg::ST_STEP && ctrl.hw_dis // R9
                                   && !ctrl.inc_mem && !kill |=> busy)
    else $error("transfer ended without memory stepping");
  chk_term_stops: assert property (busy && hw_term |=> !busy) // R9
    else $error("terminate did not end transfer");
  chk_read_addr: assert property ($rose(ibus_o.req) && !ibus_o.we // R11
                                  |-> ibus_o.addr == (ctrl.dir ? mem_addr : dev_addr))
    else $error("read address wrong for direction");
  chk_write_addr: assert property ($rose(ibus_o.req) && ibus_o.we // R11
                                   |-> ibus_o.addr == (ctrl.dir ? dev_addr : mem_addr))
    else $error("write address wrong for direction");
  chk_busy_bit: assert property (ctl_word[`CTL_BUSY] == (state != dma_chan_pkg::ST_IDLE)) // R12
    else $error("busy bit wrong");
  chk_done_bit: assert property (ctl_word[`CTL_DONE] == // R13
                                 (ctl_word[`CTL_RUN] && !ctl_word[`CTL_BUSY]))
    else $error("done bit wrong");
  chk_req_bit: assert property (ctl_word[`CTL_REQ] == fc_req[ctrl.src]) // R14
    else $error("request bit wrong");
  chk_run_ignore: assert property (!busy && !ctrl.run && !ctrl.go |=> !busy) // R15
    else $error("request taken with run off");
  chk_done_flag: assert property (set_done |=> st_done && !busy) // R16
    else $error("completion not flagged");
  chk_inactive_idle: assert property (!operational |=> !busy) // R17
    else $error("channel ran while inactive");
  chk_reserved_zero: assert property (ctl_word[31:26] == 6'h00 && !ctl_word[23] // R18
                                      && ctl_word[7:6] == 2'h0 && ctl_word[4:3] == 2'h0)
    else $error("reserved control bits not zero");
  chk_go_clear: assert property (to_idle && !wr_ctl |=> !ctrl.go && !ctrl.abort) // R19
    else $error("go or abort not cleared");
  chk_abort_idle: assert property (!busy && ctrl.abort && !wr_ctl |=> !ctrl.abort) // R19
    else $error("idle abort not cleared");
  chk_bus_err: assert property (bus_fail |=> st_err && !busy)
    else $error("bus error not flagged");
  chk_flush_idle: assert property (to_idle |=> !fifo_out_valid)
    else $error("fifo kept data after transfer");
  chk_read_data: assert property (avs_read && avs_waitrequest
                                  |=> avs_readdata == $past(rd_word))
    else $error("read data not registered");
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
                                 |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");

  cov_fw_packet: cover property (fw_go && !busy ##[1:40] state == dma_chan_pkg::ST_STEP);
  cov_end_reached: cover property (set_done);
  cov_abort_mid: cover property (state == dma_chan_pkg::ST_WRITE && ctrl.abort);
  cov_hw_term: cover property (busy && hw_term);
  cov_bus_err: cover property (bus_fail);
endmodule
`default_nettype wire

// >>> dma_channel_control_tb.sv
/*
  Self-checking bench for the channel control block.
  Assumes the far-side model and the design's register map.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dma_chan_defines.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module dma_channel_control_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [`FC_WIDTH-1:0] fc_req;
  logic [`FC_WIDTH-1:0] fc_term;
  logic fc_done, arb_req, arb_lock, arb_grant, ibus_ack, ibus_err;
  dma_chan_pkg::ibus_req_t ibus_o;
  logic [31:0] ibus_rdata, last_raddr, last_waddr, last_wdata, d;
  logic [6:0] idx = 7'h00;
  logic req_on = 1'b0;
  logic term_on = 1'b0;
  logic err_on = 1'b0;
  logic [3:0] dly = 4'h0;
  logic saw_lock = 1'b0;
  int rd_cnt, wr_cnt, r0, w0, f0;
  int fcd_cnt = 0;
  int fails = 0;
  int compares = 0;
  logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h30};
  logic [31:0] ctl [4] = '{32'h0011_0A01, 32'h0011_0A00, 32'h0019_0A01, 32'h0011_0A01};
  logic [6:0] ix [4] = '{7'h06, 7'h05, 7'h05, 7'h05};

  dma_channel_control u_dma_channel_control (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fc_req(fc_req), .fc_term(fc_term), .fc_done(fc_done), .arb_req(arb_req),
    .arb_lock(arb_lock), .arb_grant(arb_grant), .ibus_o(ibus_o),
    .ibus_ack(ibus_ack), .ibus_err(ibus_err), .ibus_rdata(ibus_rdata));
  dma_chan_far_model u_dma_chan_far_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .arb_req(arb_req), .arb_grant(arb_grant), .ibus_o(ibus_o), .ibus_ack(ibus_ack),
    .ibus_err(ibus_err), .ibus_rdata(ibus_rdata), .fc_req(fc_req), .fc_term(fc_term),
    .idx(idx), .req_on(req_on), .term_on(term_on), .err_on(err_on), .dly(dly),
    .rd_cnt(rd_cnt), .wr_cnt(wr_cnt), .last_raddr(last_raddr), .last_waddr(last_waddr),
    .last_wdata(last_wdata));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // event monitors
  always @(posedge ref_clk) begin
    if (fc_done === 1'b1) fcd_cnt++;
    if (arb_lock === 1'b1) saw_lock = 1'b1;
  end

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus_rd(8'h10, d);
      n++;
    end while (d[5] !== 1'b0 && n < 300);
    `CHK("idle", 1'b0, d[5])
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(40 * 60000);
    fails++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (offs[i]) begin
      bus_rd(offs[i], d);
      `CHK("reset", 32'h0, d)
    end
    bus_wr(8'h10, 32'hFCFF_FFFF);
    bus_rd(8'h10, d);
    `CHK("ctl_rw", 32'h007F_FF05, d)
    bus_wr(8'h10, 32'h0);
    bus_rd(8'h10, d);
    `CHK("done_off", 32'h0, d)
    bus_wr(8'h40, 32'hFFFF_FFFF);
    bus_rd(8'h40, d);
    `CHK("unmapped", 32'h0, d)
    // channel active, controller not
    bus_wr(8'h00, 32'h1);
    r0 = rd_cnt;
    bus_wr(8'h10, 32'h0148_0000);
    repeat (20) @(posedge ref_clk);
    `CHK("no_main", r0, rd_cnt)
    bus_wr(8'h10, 32'h0);
    bus_wr(8'h30, 32'h1);
    // firmware, memory to device, 3 packets of 4
    bus_wr(8'h04, 32'h100);
    bus_wr(8'h08, 32'h10C);
    bus_wr(8'h0C, 32'h200);
    r0 = rd_cnt;
    w0 = wr_cnt;
    bus_wr(8'h10, 32'h014F_0100);
    wait_idle();
    `CHK("reads", r0 + 3, rd_cnt)
    `CHK("writes", w0 + 3, wr_cnt)
    `CHK("raddr", 32'h108, last_raddr)
    `CHK("waddr", 32'h208, last_waddr)
    `CHK("wdata", {16'h0108, 16'h5AC3}, last_wdata)
    `CHK("lock", 1'b1, saw_lock)
    bus_rd(8'h04, d);
    `CHK("mem", 32'h10C, d)
    bus_rd(8'h0C, d);
    `CHK("dev", 32'h20C, d)
    bus_rd(8'h14, d);
    `CHK("sts_done", 32'h4, d)
    bus_rd(8'h10, d);
    `CHK("go_clr", 32'h004F_0100, d)
    bus_wr(8'h14, 32'h4);
    bus_rd(8'h14, d);
    `CHK("sts_clr", 32'h0, d)
    // firmware, device to memory, no memory step, slow bus, abort
    dly <= 4'h3;
    bus_wr(8'h0C, 32'h400);
    bus_wr(8'h10, 32'h012A_0000);
    repeat (60) @(posedge ref_clk);
    bus_rd(8'h10, d);
    `CHK("running", 1'b1, d[5])
    `CHK("waddr_fix", 32'h10C, last_waddr)
    `CHK("raddr_dev", 24'h000004, last_raddr[31:8])
    bus_wr(8'h10, 32'h022A_0000);
    wait_idle();
    r0 = rd_cnt;
    repeat (20) @(posedge ref_clk);
    `CHK("aborted", r0, rd_cnt)
    bus_rd(8'h10, d);
    `CHK("abort_clr", 32'h002A_0000, d)
    bus_rd(8'h14, d);
    `CHK("no_done", 32'h0, d)
    dly <= 4'h0;
    // bus error on first read
    err_on <= 1'b1;
    bus_wr(8'h04, 32'h500);
    bus_wr(8'h08, 32'h510);
    r0 = rd_cnt;
    w0 = wr_cnt;
    bus_wr(8'h10, 32'h014F_0100);
    wait_idle();
    `CHK("err_rd", r0 + 1, rd_cnt)
    `CHK("err_wr", w0, wr_cnt)
    bus_rd(8'h14, d);
    `CHK("buserr", 32'h1, d)
    err_on <= 1'b0;
    bus_wr(8'h14, 32'h1);
    bus_rd(8'h14, d);
    `CHK("buserr_clr", 32'h0, d)
    // hardware paced, source 5, size 1
    bus_wr(8'h04, 32'h300);
    bus_wr(8'h08, 32'h301);
    f0 = fcd_cnt;
    r0 = rd_cnt;
    idx <= 7'h05;
    req_on <= 1'b1;
    bus_wr(8'h10, 32'h0011_0A01);
    for (int k = 0; k < 200 && fcd_cnt == f0; k++) @(posedge ref_clk);
    bus_rd(8'h10, d);
    `CHK("req_on", 1'b1, d[1])
    req_on <= 1'b0;
    wait_idle();
    `CHK("fc_done", 1'b1, fcd_cnt > f0)
    `CHK("hw_read", 1'b1, rd_cnt > r0)
    bus_rd(8'h14, d);
    `CHK("hw_done", 1'b1, d[2])
    bus_rd(8'h10, d);
    `CHK("hw_ctl", 32'h0011_0A05, d)
    bus_wr(8'h14, 32'h4);
    // wrong source, run off, pacing disabled, terminated: nothing moves
    for (int i = 0; i < 4; i++) begin
      bus_wr(8'h10, ctl[i]);
      idx <= ix[i];
      term_on <= (i == 3);
      req_on <= 1'b1;
      r0 = rd_cnt;
      repeat (30) @(posedge ref_clk);
      `CHK("ignored", r0, rd_cnt)
      bus_wr(8'h10, 32'h0);
      req_on <= 1'b0;
    end
    wrap_up();
  end
endmodule
`default_nettype wire
